// ---- dv/cpu_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Requests from the bench
   input wire logic issue,
   input wire logic use_lpm,
   input wire logic [2:0] delay,
   // Core side of the sequencer
   input wire logic cpu_halt,
   output logic spm_strobe,
   output logic lpm_strobe
);
   logic [2:0] cnt;
   logic kind;

   // Runs the instruction after delay cycles; a halted core stands still
   always_ff @(posedge mclk) begin
      spm_strobe <= 1'b0;
      lpm_strobe <= 1'b0;
      if (rst) begin
         cnt <= 3'h0;
      end else if (issue) begin
         kind <= use_lpm;
         cnt <= delay;
         spm_strobe <= !use_lpm && delay == 3'h0;
         lpm_strobe <= use_lpm && delay == 3'h0;
      end else if (cnt != 3'h0 && !cpu_halt) begin
         cnt <= cnt - 3'h1;
         spm_strobe <= !kind && cnt == 3'h1;
         lpm_strobe <= kind && cnt == 3'h1;
      end
   end
endmodule
`default_nettype wire

// ---- dv/flash_self_programming_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module flash_self_programming_ctrl_test;
   localparam int unsigned PC = 20;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, got;
   logic avs_waitrequest, spm_strobe, lpm_strobe, cpu_halt;
   logic eeprom_write_pending = 1'b0;
   logic eeprom_write_start = 1'b0;
   logic issue = 1'b0;
   logic use_lpm = 1'b0;
   logic [2:0] delay = 3'h0;
   logic flash_erase_go, flash_prog_valid, flash_rd_valid, flash_rd_byte_sel;
   logic [9:0] flash_prog_page;
   logic [4:0] flash_prog_word;
   logic [15:0] flash_prog_data, p;
   logic [14:0] flash_rd_word_addr;
   logic [15:0] buf_exp [32];
   logic [31:0] mask;
   logic [31:0] q_rd [$];
   logic [31:0] q_fl [$];
   int fails = 0;
   int compares = 0;
   int seed = 35789;

   // ----------------------------------------
   // Clock, design and core
   // ----------------------------------------
   always #10 mclk = ~mclk;

   flash_self_programming_ctrl #(.PROG_CYCLES(PC)) i_dut (.mclk(mclk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .spm_strobe(spm_strobe),
      .lpm_strobe(lpm_strobe), .cpu_halt(cpu_halt),
      .eeprom_write_pending(eeprom_write_pending),
      .eeprom_write_start(eeprom_write_start), .flash_erase_go(flash_erase_go),
      .flash_prog_valid(flash_prog_valid), .flash_prog_page(flash_prog_page),
      .flash_prog_word(flash_prog_word), .flash_prog_data(flash_prog_data),
      .flash_rd_valid(flash_rd_valid), .flash_rd_word_addr(flash_rd_word_addr),
      .flash_rd_byte_sel(flash_rd_byte_sel));

   cpu_core_model i_core (.mclk(mclk), .rst(rst), .issue(issue), .use_lpm(use_lpm),
      .delay(delay), .cpu_halt(cpu_halt), .spm_strobe(spm_strobe),
      .lpm_strobe(lpm_strobe));

   // ----------------------------------------
   // Compare, report and bus tasks
   // ----------------------------------------
   task automatic chk_bus(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED bus at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_fl(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED flash at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic close_out;
      fails += q_fl.size() + q_rd.size();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      q_rd.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask

   // ----------------------------------------
   // Command tasks
   // ----------------------------------------
   task automatic core(input logic l, input logic [2:0] d);
      use_lpm <= l;
      delay <= d;
      issue <= 1'b1;
      @(posedge mclk);
      issue <= 1'b0;
   endtask

   task automatic cmd(input logic [15:0] ptr, input logic [7:0] c, input logic [2:0] d);
      bus(1'b1, flash_spm_pkg::OFS_PTR, {16'h0, ptr});
      bus(1'b1, flash_spm_pkg::OFS_CTRL, {24'h0, c});
      core(1'b0, d);
   endtask

   task automatic clr;
      for (int i = 0; i < 32; i++) buf_exp[i] = 16'hffff;
      mask = 32'h0;
   endtask

   task automatic load(input logic [4:0] w, input logic [2:0] d);
      logic [15:0] v;
      v = $random(seed);
      p = $random(seed);
      p[5:1] = w;
      bus(1'b1, flash_spm_pkg::OFS_DATA, {16'h0, v});
      cmd(p, flash_spm_pkg::CMD_LOAD, d);
      if (d < 3'h3 && !mask[w]) buf_exp[w] = v;
      if (d < 3'h3) mask[w] = 1'b1;
   endtask

   task automatic wait_op;
      int n;
      n = 0;
      while (cpu_halt !== 1'b1 && n < 8) begin
         @(posedge mclk);
         n++;
      end
      chk_bus({31'h0, cpu_halt}, 32'h1);
      while (cpu_halt !== 1'b0) @(posedge mclk);
   endtask

   task automatic do_page(input logic [9:0] pg, input logic [2:0] d);
      q_fl.push_back({6'h10, pg, 16'h0});
      cmd({pg, 6'h2b}, flash_spm_pkg::CMD_ERASE, d);
      wait_op();
      for (int i = 0; i < 32; i++) q_fl.push_back({1'b0, pg, i[4:0], buf_exp[i]});
      cmd({pg, 6'h00}, flash_spm_pkg::CMD_WRITE, d);
      wait_op();
      clr();
   endtask

   // Compares every result with the oldest note
   always @(posedge mclk) begin
      if (avs_read && avs_waitrequest === 1'b0) chk_bus(avs_readdata, q_rd.pop_front());
      got = {6'h10, flash_prog_page, 16'h0};
      if (flash_erase_go === 1'b1) chk_fl(got, q_fl.pop_front());
      got = {1'b0, flash_prog_page, flash_prog_word, flash_prog_data};
      if (flash_prog_valid === 1'b1) chk_fl(got, q_fl.pop_front());
      got = {16'h4000, flash_rd_word_addr, flash_rd_byte_sel};
      if (flash_rd_valid === 1'b1) chk_fl(got, q_fl.pop_front());
   end

   // Watchdog
   initial begin
      #1000000;
      fails++;
      close_out();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clr();
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      rd(flash_spm_pkg::OFS_CTRL, 32'h0);
      rd(flash_spm_pkg::OFS_PTR, 32'h0);
      rd(flash_spm_pkg::OFS_STATUS, 32'h0);
      rd(4'h2, 32'h0);
      $display("test reset done");
      load(5'd7, 3'h0);
      load(5'd2, 3'h2);
      load(5'd20, 3'h0);
      load(5'd31, 3'h1);
      do_page(10'h2a5, 3'h0);
      do_page(10'h3ff, 3'h2);
      $display("test page done");
      load(5'd4, 3'h3);
      repeat (2) @(posedge mclk);
      rd(flash_spm_pkg::OFS_CTRL, 32'h0);
      load(5'd9, 3'h0);
      eeprom_write_start <= 1'b1;
      @(posedge mclk);
      eeprom_write_start <= 1'b0;
      rd(flash_spm_pkg::OFS_STATUS, 32'h0);
      clr();
      load(5'd12, 3'h0);
      bus(1'b1, flash_spm_pkg::OFS_CTRL, 32'h10);
      clr();
      do_page(10'h000, 3'h0);
      $display("test clear done");
      eeprom_write_pending <= 1'b1;
      bus(1'b1, flash_spm_pkg::OFS_CTRL, {24'h0, flash_spm_pkg::CMD_ERASE});
      rd(flash_spm_pkg::OFS_CTRL, 32'h0);
      rd(flash_spm_pkg::OFS_STATUS, 32'h4);
      core(1'b0, 3'h0);
      repeat (4) @(posedge mclk);
      chk_bus({31'h0, cpu_halt}, 32'h0);
      eeprom_write_pending <= 1'b0;
      $display("test eeprom done");
      p = $random(seed);
      bus(1'b1, flash_spm_pkg::OFS_PTR, {16'h0, p});
      q_fl.push_back({16'h4000, p});
      core(1'b1, 3'h1);
      repeat (4) @(posedge mclk);
      $display("test read done");
      load(5'd5, 3'h0);
      q_fl.push_back({6'h10, 10'h155, 16'h0});
      cmd({10'h155, 6'h00}, flash_spm_pkg::CMD_ERASE, 3'h0);
      repeat (4) @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      clr();
      do_page(10'h155, 3'h1);
      $display("test reset mid-run done");
      close_out();
   end
endmodule

bind flash_self_programming_ctrl flash_spm_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
   .mclk(mclk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .spm_strobe(spm_strobe), .lpm_strobe(lpm_strobe),
   .eeprom_write_pending(eeprom_write_pending), .cpu_halt(cpu_halt),
   .flash_erase_go(flash_erase_go), .flash_prog_valid(flash_prog_valid),
   .flash_prog_page(flash_prog_page), .flash_prog_word(flash_prog_word),
   .flash_rd_valid(flash_rd_valid));
`default_nettype wire

// ---- dv/flash_spm_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module flash_spm_asserts #(
   parameter int unsigned PROG_CYCLES = 20
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Bus and core
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic spm_strobe,
   input wire logic lpm_strobe,
   input wire logic eeprom_write_pending,
   input wire logic cpu_halt,
   // Flash side
   input wire logic flash_erase_go,
   input wire logic flash_prog_valid,
   input wire logic [flash_spm_pkg::PAGE_W-1:0] flash_prog_page,
   input wire logic [flash_spm_pkg::WORD_W-1:0] flash_prog_word,
   input wire logic flash_rd_valid
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // Length of the current halt
   logic [31:0] halt_len;
   always_ff @(posedge mclk) begin
      if (rst || !cpu_halt) halt_len <= 32'h0;
      else halt_len <= halt_len + 32'h1;
   end

   erase_halts_a: assert property (flash_erase_go |-> cpu_halt)
      else $error("erase pulse without halt");
   prog_halts_a: assert property (flash_prog_valid |-> cpu_halt)
      else $error("page program without halt");
   halt_cause_a: assert property ($rose(cpu_halt) |-> $past(spm_strobe) && !$past(eeprom_write_pending))
      else $error("halt without an allowed store-program");
   burst_start_a: assert property ($rose(flash_prog_valid) |-> flash_prog_word == 5'h00)
      else $error("burst does not start at word zero");
   burst_step_a: assert property (flash_prog_valid && $past(flash_prog_valid) |->
      flash_prog_word == $past(flash_prog_word) + 5'h01 && $stable(flash_prog_page))
      else $error("burst word or page step wrong");
   burst_end_a: assert property (flash_prog_valid && flash_prog_word == 5'h1f |=> !flash_prog_valid)
      else $error("burst longer than a page");
   halt_time_a: assert property ($fell(cpu_halt) |->
      halt_len >= PROG_CYCLES - 1 && halt_len <= PROG_CYCLES + 40)
      else $error("halt length out of range");
   read_addr_a: assert property (flash_rd_valid |-> $past(lpm_strobe) && !$past(cpu_halt))
      else $error("flash read without load-program");
   bus_answer_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");

   // Main scenarios reached
   cover property ($rose(flash_erase_go));
   cover property ($fell(flash_prog_valid));
   cover property (flash_rd_valid);
endmodule
`default_nettype wire

// ---- rtl/flash_self_programming_ctrl.sv ----
// Function
// - Erase code plus store-program within four cycles erases the pointer's page.
// - Erase uses only the page field; data pair and other pointer bits ignored.
// - CPU is halted for the whole page erase.
// - Load code plus store-program within four cycles stores data pair at word field.
// - Buffer clears after page write, on re-enable bit write, and on reset.
// - An EEPROM write during page loading discards all loaded words.
// - Write code plus store-program within four cycles programs buffer into page.
// - CPU is halted for the whole page write.
// - Buffer words may be loaded in any order.
// - Buffer may be filled before erase or between erase and write.
// - Word address splits into word-in-page low bits and page high bits.
// - Load-program reads address by byte, pointer bit 0 picks the byte.
// - While EEPROM write pends, programming commands are blocked.
// - Store-program is accepted from code at any address.
// - Each erase or write takes 3.7 to 4.5 ms.
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module flash_self_programming_ctrl #(
   parameter int unsigned PROG_CYCLES = flash_spm_pkg::PROG_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [flash_spm_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Processor core
   input wire logic spm_strobe,
   input wire logic lpm_strobe,
   output logic cpu_halt,
   // EEPROM controller
   input wire logic eeprom_write_pending,
   input wire logic eeprom_write_start,
   // Flash array, programming side
   output logic flash_erase_go,
   output logic flash_prog_valid,
   output logic [flash_spm_pkg::PAGE_W-1:0] flash_prog_page,
   output logic [flash_spm_pkg::WORD_W-1:0] flash_prog_word,
   output logic [flash_spm_pkg::DATA_W-1:0] flash_prog_data,
   // Flash array, read side
   output logic flash_rd_valid,
   output logic [flash_spm_pkg::PTR_W-2:0] flash_rd_word_addr,
   output logic flash_rd_byte_sel
);

   // ----------------------------------------
   // Pointer field decode
   // ----------------------------------------

   // Page index from the high pointer bits
   function automatic logic [flash_spm_pkg::PAGE_W-1:0] page_of(
      input logic [flash_spm_pkg::PTR_W-1:0] p);
      page_of = p[flash_spm_pkg::PAGE_LSB +: flash_spm_pkg::PAGE_W];
   endfunction

   // Word within page from the low pointer bits
   function automatic logic [flash_spm_pkg::WORD_W-1:0] word_of(
      input logic [flash_spm_pkg::PTR_W-1:0] p);
      word_of = p[flash_spm_pkg::WORD_LSB +: flash_spm_pkg::WORD_W];
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [flash_spm_pkg::CTRL_W-1:0] store_program_control_reg;
   logic [flash_spm_pkg::PTR_W-1:0] pointer;
   logic [flash_spm_pkg::DATA_W-1:0] load_data_pair;
   logic [2:0] window_cnt;
   flash_spm_pkg::seq_state_type state;
   logic [flash_spm_pkg::WORD_W-1:0] stream_idx;
   logic [flash_spm_pkg::PAGE_W-1:0] op_page;
   logic bus_take;
   logic wr_ctrl;
   logic window_open;
   logic spm_fire;
   logic do_load;
   logic do_erase;
   logic do_write;
   logic buf_clear;
   logic buf_loaded;
   logic [flash_spm_pkg::DATA_W-1:0] buf_rd_data;
   logic timer_start;
   logic timer_done;
   logic [31:0] next_readdata;

   // ----------------------------------------
   // Avalon-MM handshake
   // ----------------------------------------

   // Request taken at the edge where waitrequest is low
   assign bus_take = (avs_read || avs_write) && !avs_waitrequest;

   // Waitrequest drops for one cycle after a request is seen
   always_ff @(posedge mclk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else if (!avs_waitrequest) begin
         avs_waitrequest <= 1'b1;
      end else if (avs_read || avs_write) begin
         avs_waitrequest <= 1'b0;
      end
   end

   // Read mux, unmapped offsets read zero
   always_comb begin
      next_readdata = '0;
      case (avs_address)
         flash_spm_pkg::OFS_CTRL: begin
            next_readdata[flash_spm_pkg::CTRL_W-1:0] = store_program_control_reg;
         end
         flash_spm_pkg::OFS_PTR: begin
            next_readdata[flash_spm_pkg::PTR_W-1:0] = pointer;
         end
         flash_spm_pkg::OFS_DATA: begin
            next_readdata[flash_spm_pkg::DATA_W-1:0] = load_data_pair;
         end
         flash_spm_pkg::OFS_STATUS: begin
            next_readdata[flash_spm_pkg::ST_BUSY_BIT] = (state != flash_spm_pkg::st_idle);
            next_readdata[flash_spm_pkg::ST_WINDOW_BIT] = window_open;
            next_readdata[flash_spm_pkg::ST_EEPROM_BIT] = eeprom_write_pending;
            next_readdata[flash_spm_pkg::ST_LOADED_BIT] = buf_loaded;
         end
         default: begin
            next_readdata = '0;
         end
      endcase
   end

   // Read data registered while the request waits
   always_ff @(posedge mclk) begin
      if (rst) begin
         avs_readdata <= '0;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= next_readdata;
      end
   end

   // ----------------------------------------
   // Control register write and command window
   // ----------------------------------------

   // Control writes refused while busy or while EEPROM write pends
   assign wr_ctrl = bus_take && avs_write && avs_address == flash_spm_pkg::OFS_CTRL
      && state == flash_spm_pkg::st_idle && !eeprom_write_pending;

   assign window_open = (window_cnt != 3'h0);

   // Store-program honoured from any code address while window runs
   assign spm_fire = spm_strobe && window_open && !eeprom_write_pending;

   assign do_load = spm_fire && store_program_control_reg == flash_spm_pkg::CMD_LOAD;
   assign do_erase = spm_fire && store_program_control_reg == flash_spm_pkg::CMD_ERASE;
   assign do_write = spm_fire && store_program_control_reg == flash_spm_pkg::CMD_WRITE;

   // Window counter opens for four cycles on a command write
   always_ff @(posedge mclk) begin
      if (rst) begin
         window_cnt <= 3'h0;
      end else if (wr_ctrl && avs_writedata[flash_spm_pkg::CTRL_ENABLE_BIT]) begin
         window_cnt <= flash_spm_pkg::WINDOW_CYCLES;
      end else if (spm_fire) begin
         window_cnt <= 3'h0;
      end else if (window_open) begin
         window_cnt <= window_cnt - 3'h1;
      end
   end

   // Command bits cleared on expiry, on load, and at end of operation
   always_ff @(posedge mclk) begin
      if (rst) begin
         store_program_control_reg <= flash_spm_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         store_program_control_reg <= avs_writedata[flash_spm_pkg::CTRL_W-1:0];
      end else if (window_cnt == 3'h1 && !spm_fire) begin
         store_program_control_reg <= flash_spm_pkg::CTRL_RESET;
      end else if (do_load || timer_done) begin
         store_program_control_reg <= flash_spm_pkg::CTRL_RESET;
      end
   end

   // ----------------------------------------
   // Pointer and data pair registers
   // ----------------------------------------

   // Loaded only while idle so a running operation keeps its operands
   always_ff @(posedge mclk) begin
      if (rst) begin
         pointer <= flash_spm_pkg::PTR_RESET;
         load_data_pair <= flash_spm_pkg::DATA_RESET;
      end else if (bus_take && avs_write && state == flash_spm_pkg::st_idle) begin
         if (avs_address == flash_spm_pkg::OFS_PTR) begin
            pointer <= avs_writedata[flash_spm_pkg::PTR_W-1:0];
         end
         if (avs_address == flash_spm_pkg::OFS_DATA) begin
            load_data_pair <= avs_writedata[flash_spm_pkg::DATA_W-1:0];
         end
      end
   end

   // ----------------------------------------
   // Temporary page buffer
   // ----------------------------------------

   // Clear after page write, on re-enable bit write, on EEPROM write
   assign buf_clear = (state == flash_spm_pkg::st_program && timer_done)
      || (wr_ctrl && avs_writedata[flash_spm_pkg::CTRL_RWW_BIT])
      || eeprom_write_start;

   page_buffer u_buffer (
      .mclk(mclk),
      .rst(rst),
      .clear(buf_clear),
      .load(do_load),
      .load_idx(word_of(pointer)),
      .load_data(load_data_pair),
      .rd_idx(stream_idx),
      .rd_data(buf_rd_data),
      .loaded(buf_loaded)
   );

   // ----------------------------------------
   // Programming time
   // ----------------------------------------
   assign timer_start = do_erase
      || (state == flash_spm_pkg::st_stream && stream_idx == '1);

   op_timer #(
      .CYCLES(PROG_CYCLES)
   ) u_timer (
      .mclk(mclk),
      .rst(rst),
      .start(timer_start),
      .done(timer_done)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------

   // Erase waits on the timer, write streams the buffer then waits
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= flash_spm_pkg::st_idle;
         stream_idx <= '0;
         op_page <= '0;
      end else begin
         case (state)
            flash_spm_pkg::st_idle: begin
               stream_idx <= '0;
               if (do_erase) begin
                  op_page <= page_of(pointer);
                  state <= flash_spm_pkg::st_erase;
               end else if (do_write) begin
                  op_page <= page_of(pointer);
                  state <= flash_spm_pkg::st_stream;
               end
            end
            flash_spm_pkg::st_erase: begin
               if (timer_done) begin
                  state <= flash_spm_pkg::st_idle;
               end
            end
            flash_spm_pkg::st_stream: begin
               stream_idx <= stream_idx + 1'b1;
               if (stream_idx == '1) begin
                  state <= flash_spm_pkg::st_program;
               end
            end
            flash_spm_pkg::st_program: begin
               if (timer_done) begin
                  state <= flash_spm_pkg::st_idle;
               end
            end
            default: begin
               state <= flash_spm_pkg::st_idle;
            end
         endcase
      end
   end

   // CPU halt for the whole erase or write
   always_ff @(posedge mclk) begin
      if (rst) begin
         cpu_halt <= 1'b0;
      end else if (do_erase || do_write) begin
         cpu_halt <= 1'b1;
      end else if (timer_done) begin
         cpu_halt <= 1'b0;
      end
   end

   // ----------------------------------------
   // Flash array programming outputs
   // ----------------------------------------

   // Erase pulse, then buffer words one per cycle to the array
   always_ff @(posedge mclk) begin
      if (rst) begin
         flash_erase_go <= 1'b0;
         flash_prog_valid <= 1'b0;
         flash_prog_page <= '0;
         flash_prog_word <= '0;
         flash_prog_data <= '0;
      end else begin
         flash_erase_go <= do_erase;
         flash_prog_valid <= (state == flash_spm_pkg::st_stream);
         if (do_erase || do_write) begin
            flash_prog_page <= page_of(pointer);
         end else begin
            flash_prog_page <= op_page;
         end
         flash_prog_word <= stream_idx;
         flash_prog_data <= buf_rd_data;
      end
   end

   // ----------------------------------------
   // Load-program read address
   // ----------------------------------------

   // Byte addressing, pointer bit 0 selects the byte
   always_ff @(posedge mclk) begin
      if (rst) begin
         flash_rd_valid <= 1'b0;
         flash_rd_word_addr <= '0;
         flash_rd_byte_sel <= 1'b0;
      end else begin
         flash_rd_valid <= lpm_strobe && state == flash_spm_pkg::st_idle;
         if (lpm_strobe) begin
            flash_rd_word_addr <= pointer[flash_spm_pkg::PTR_W-1:1];
            flash_rd_byte_sel <= pointer[0];
         end
      end
   end

endmodule

`default_nettype wire

// ---- rtl/flash_spm_pkg.sv ----
package flash_spm_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_PTR = 4'h4;
   localparam logic [3:0] OFS_DATA = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;

   // ----------------------------------------
   // Control register codes and fields
   // ----------------------------------------
   localparam int unsigned CTRL_W = 8;
   localparam logic [7:0] CMD_LOAD = 8'h01;
   localparam logic [7:0] CMD_ERASE = 8'h03;
   localparam logic [7:0] CMD_WRITE = 8'h05;
   localparam int unsigned CTRL_ENABLE_BIT = 0;
   localparam int unsigned CTRL_RWW_BIT = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ----------------------------------------
   // Status register fields
   // ----------------------------------------
   localparam int unsigned ST_BUSY_BIT = 0;
   localparam int unsigned ST_WINDOW_BIT = 1;
   localparam int unsigned ST_EEPROM_BIT = 2;
   localparam int unsigned ST_LOADED_BIT = 3;

   // ----------------------------------------
   // Pointer split and buffer shape
   // ----------------------------------------
   localparam int unsigned PTR_W = 16;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned WORD_LSB = 1;
   localparam int unsigned WORD_W = 5;
   localparam int unsigned PAGE_LSB = 6;
   localparam int unsigned PAGE_W = 10;
   localparam int unsigned PAGE_WORDS = 32;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [15:0] DATA_RESET = 16'h0000;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam logic [2:0] WINDOW_CYCLES = 3'h4;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned PROG_MIN_NS = 3700000;
   localparam int unsigned PROG_MAX_NS = 4500000;
   localparam int unsigned PROG_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMER_W = 20;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      st_idle,
      st_erase,
      st_stream,
      st_program
   } seq_state_type;

endpackage

// ---- rtl/op_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module op_timer #(
   parameter int unsigned CYCLES = flash_spm_pkg::PROG_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Control
   input wire logic start,
   output logic done
);

   localparam logic [flash_spm_pkg::TIMER_W-1:0] LAST =
      flash_spm_pkg::TIMER_W'(CYCLES - 1);

   logic [flash_spm_pkg::TIMER_W-1:0] count;
   logic running;

   // ----------------------------------------
   // Countdown, done pulses CYCLES edges after start
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         count <= '0;
         running <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            count <= LAST;
            running <= 1'b1;
         end else if (running) begin
            if (count == '0) begin
               running <= 1'b0;
            end else begin
               count <= count - 1'b1;
            end
            done <= (count == '0);
         end
      end
   end

endmodule

`default_nettype wire

// ---- rtl/page_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none

module page_buffer (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Control
   input wire logic clear,
   input wire logic load,
   input wire logic [flash_spm_pkg::WORD_W-1:0] load_idx,
   input wire logic [flash_spm_pkg::DATA_W-1:0] load_data,
   // Read side
   input wire logic [flash_spm_pkg::WORD_W-1:0] rd_idx,
   output logic [flash_spm_pkg::DATA_W-1:0] rd_data,
   output logic loaded
);

   logic [flash_spm_pkg::DATA_W-1:0] mem [flash_spm_pkg::PAGE_WORDS];
   logic [flash_spm_pkg::PAGE_WORDS-1:0] valid;

   // ----------------------------------------
   // Word storage, one cell per word
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < flash_spm_pkg::PAGE_WORDS; gi++) begin : g_word
         // Erased cells read as all ones
         always_ff @(posedge mclk) begin
            if (rst || clear) begin
               mem[gi] <= '1;
               valid[gi] <= 1'b0;
            end else if (load && load_idx == flash_spm_pkg::WORD_W'(gi) && !valid[gi]) begin
               mem[gi] <= load_data;
               valid[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   // Read mux and loaded flag
   assign rd_data = mem[rd_idx];
   assign loaded = |valid;

endmodule

`default_nettype wire
